/* logic/bus_io_slave.sv */
// control logic of the bus i/o slave: decode, transceivers, acknowledge, interrupt, chip selects
`timescale 1ns/100ps

// Function
// - transceivers rest inward when idle or writing
// - direction follows qualified read strobe only
// - direction settles before transceiver enable
// - read/write strobes gated by base match
// - idle board holds acknowledge register cleared
// - selected board shifts high per constant clock
// - acknowledge from selectable tap, three-four periods
// - delay covers 250 ns chip read
// - request flag drives shared open-collector interrupt
// - port zero read copies request to status
// - status bit0 set, stable during read
// - port zero write clears request unless a request rises with it
// - even ports low chip, odd high
// - byte-high enable also selects high chip
// - address stable before chip strobes
// - narrow variant: one transceiver, board select
// - narrow variant: chips at 8-B, C-F
// - match address bits 4-B to base, 4-7 only for narrow hosts
// - odd bytes via swap path, words both lanes
module bus_io_slave
	import slave_io_pkg::*;
#(
	parameter bit WIDE_BUS = 1'b1,
	parameter int ACK_SEL  = slave_io_pkg::ACK_TAP
) (
	// clock and reset
	input  wire logic                            clk,
	input  wire logic                            rst_b,
	// bus commands and address, active low pins
	input  wire logic                            ioReadCmd_n,
	input  wire logic                            ioWriteCmd_n,
	input  wire logic [slave_io_pkg::ADDR_W-1:0] addr_n,
	input  wire logic                            byteHighEnable_n,
	input  wire logic                            constClk_n,
	// jumpers
	input  wire logic [slave_io_pkg::BASE_W-1:0] baseAddr,
	input  wire logic                            narrowHost,
	// external interrupt source
	input  wire logic                            extIrqReq,
	// acknowledge tri-state pin
	output logic                                 xackOut_n,
	output logic                                 xackOe,
	// shared interrupt line, open collector
	output logic                                 intLineOut,
	output logic                                 intLineOe,
	// transceiver control
	output logic                                 xcvrSteer,
	output logic                                 xcvrLowEn,
	output logic                                 xcvrHighEn,
	output logic                                 xcvrSwapEn,
	// status driver onto on-board d0
	output logic [slave_io_pkg::STATUS_W-1:0]    statusData,
	output logic                                 statusOe,
	// parallel port chips
	output logic                                 lowChipSel_n,
	output logic                                 highChipSel_n,
	output logic [1:0]                           chipAddr,
	output logic                                 chipRead_n,
	output logic                                 chipWrite_n
);
	import slave_io_pkg::*;

	localparam int TAP_W = $clog2(ACK_DEPTH);

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [SYNC_STAGES-1:0] rdSync;
	logic [SYNC_STAGES-1:0] wrSync;
	logic [SYNC_STAGES-1:0] bheSync;
	logic [SYNC_STAGES-1:0] cclkSync;
	logic [SYNC_STAGES-1:0] irqSync;
	logic [SYNC_STAGES-1:0] narrowSync;
	logic [ADDR_W-1:0]      addrMeta;
	logic [ADDR_W-1:0]      addrSync;
	logic [BASE_W-1:0]      baseMeta;
	logic [BASE_W-1:0]      baseSync;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdSync     <= '0;
			wrSync     <= '0;
			bheSync    <= '0;
			cclkSync   <= '0;
			irqSync    <= '0;
			narrowSync <= '0;
		end else begin
			rdSync     <= {rdSync[0], ~ioReadCmd_n};
			wrSync     <= {wrSync[0], ~ioWriteCmd_n};
			bheSync    <= {bheSync[0], ~byteHighEnable_n};
			cclkSync   <= {cclkSync[0], ~constClk_n};
			irqSync    <= {irqSync[0], extIrqReq};
			narrowSync <= {narrowSync[0], narrowHost};
		end
	end

	// address lines are inverted here so everything after sees true levels
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			addrMeta <= '0;
			addrSync <= '0;
			baseMeta <= '0;
			baseSync <= '0;
		end else begin
			addrMeta <= ~addr_n;
			addrSync <= addrMeta;
			baseMeta <= baseAddr;
			baseSync <= baseMeta;
		end
	end

	// ****************************************
	// edge trackers
	// ****************************************
	logic cclkLast;
	logic irqLast;
	logic cclkTick;
	logic irqRise;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cclkLast <= 1'b0;
			irqLast  <= 1'b0;
		end else begin
			cclkLast <= cclkSync[1];
			irqLast  <= irqSync[1];
		end
	end

	assign cclkTick = cclkSync[1] & ~cclkLast;
	assign irqRise  = irqSync[1] & ~irqLast;

	// ****************************************
	// base address decode
	// ****************************************
	function automatic logic baseMatch(input logic [ADDR_W-1:0] a,
	                                   input logic [BASE_W-1:0] b,
	                                   input logic              narrow);
		logic hiOk;
		logic loOk;
		hiOk = narrow | (a[BASE_HI_LSB +: 4] == b[7:4]);
		loOk = a[BASE_LO_LSB +: 4] == b[3:0];
		return hiOk & loOk;
	endfunction : baseMatch

	logic            addrHit;
	logic [PORT_W-1:0] port;

	// narrow hosts leave bits 8-b undecoded
	assign addrHit = baseMatch(addrSync, baseSync, narrowSync[1]);
	assign port    = addrSync[PORT_LSB +: PORT_W];

	// ****************************************
	// qualified strobes
	// ****************************************
	logic readStrobe;
	logic writeStrobe;
	logic boardSel;
	logic boardSelSeen;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			readStrobe  <= 1'b0;
			writeStrobe <= 1'b0;
		end else begin
			readStrobe  <= rdSync[1] & addrHit;
			writeStrobe <= wrSync[1] & addrHit;
		end
	end

	assign boardSel = readStrobe | writeStrobe;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			boardSelSeen <= 1'b0;
		end else begin
			boardSelSeen <= boardSel;
		end
	end

	// ****************************************
	// transceiver steering
	// ****************************************
	// write strobe is kept out so removing the write never flips the path
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			xcvrSteer <= 1'b0;
		end else begin
			xcvrSteer <= readStrobe;
		end
	end

	// enables wait a cycle behind the steer flop: no fight with the master
	logic laneGo;
	logic oddByte;
	logic wordXfer;

	assign laneGo   = boardSel & boardSelSeen;
	assign oddByte  = addrSync[LANE_BIT];
	assign wordXfer = bheSync[1] & ~oddByte;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			xcvrLowEn  <= 1'b0;
			xcvrHighEn <= 1'b0;
			xcvrSwapEn <= 1'b0;
		end else if (!WIDE_BUS) begin
			xcvrLowEn  <= laneGo;
			xcvrHighEn <= 1'b0;
			xcvrSwapEn <= 1'b0;
		end else begin
			xcvrLowEn  <= laneGo & ~oddByte;
			xcvrHighEn <= laneGo & wordXfer;
			xcvrSwapEn <= laneGo & oddByte;
		end
	end

	// ****************************************
	// transfer acknowledge
	// ****************************************
	logic                  ackDone;
	logic [TAP_W-1:0]      tapSel;

	// tap n waits n to n+1 constant clock periods, so tap 3 clears the 250 ns read
	assign tapSel = TAP_W'(ACK_SEL);

	ack_delay #(
		.DEPTH    (ACK_DEPTH)
	) ackDelay (
		.clk      (clk),
		.rst_b    (rst_b),
		.boardSel (boardSel),
		.cclkTick (cclkTick),
		.tapSel   (tapSel),
		.ackDone  (ackDone)
	);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			xackOe    <= 1'b0;
			xackOut_n <= 1'b1;
		end else begin
			xackOe    <= boardSel;
			xackOut_n <= ~(ackDone & boardSel);
		end
	end

	// ****************************************
	// interrupt latches
	// ****************************************
	logic statusPort;
	logic readLast;
	logic writeLast;
	logic statusRead;
	logic statusWrite;
	logic reqFlag;
	logic statusFlag;

	assign statusPort  = port == PORT_IRQ_STATUS;
	assign statusRead  = readStrobe & ~readLast & statusPort;
	assign statusWrite = writeStrobe & ~writeLast & statusPort;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			readLast  <= 1'b0;
			writeLast <= 1'b0;
		end else begin
			readLast  <= readStrobe;
			writeLast <= writeStrobe;
		end
	end

	// sources share the line, so the master polls and clears the one it finds
	irq_latch irqLatch (
		.clk         (clk),
		.rst_b       (rst_b),
		.reqRise     (irqRise),
		.statusRead  (statusRead),
		.statusWrite (statusWrite),
		.reqFlag     (reqFlag),
		.statusFlag  (statusFlag)
	);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			intLineOe  <= 1'b0;
			intLineOut <= 1'b0;
		end else begin
			intLineOe  <= reqFlag;
			intLineOut <= 1'b0;
		end
	end

	// status driven only while the port zero read lasts
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			statusOe   <= 1'b0;
			statusData <= '0;
		end else begin
			statusOe   <= readStrobe & readLast & statusPort;
			statusData <= STATUS_W'(statusFlag) << STATUS_BIT;
		end
	end

	// ****************************************
	// parallel port chip selects
	// ****************************************
	logic chipGroup;

	assign chipGroup = addrSync[GROUP_BIT] & addrHit;

	// selects come from the address and byte-high enable alone, which lead the command by the set-up time
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lowChipSel_n  <= 1'b1;
			highChipSel_n <= 1'b1;
			chipAddr      <= '0;
		end else if (!WIDE_BUS) begin
			lowChipSel_n  <= ~(chipGroup & ~addrSync[NARROW_HALF_BIT]);
			highChipSel_n <= ~(chipGroup & addrSync[NARROW_HALF_BIT]);
			chipAddr      <= addrSync[1:0];
		end else begin
			lowChipSel_n  <= ~(chipGroup & ~oddByte);
			highChipSel_n <= ~(chipGroup & (oddByte | bheSync[1]));
			chipAddr      <= addrSync[2:1];
		end
	end

	// strobes trail the selects by the strobe pipeline, never lead them
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			chipRead_n  <= 1'b1;
			chipWrite_n <= 1'b1;
		end else begin
			chipRead_n  <= ~(readStrobe & readLast & addrSync[GROUP_BIT]);
			chipWrite_n <= ~(writeStrobe & writeLast & addrSync[GROUP_BIT]);
		end
	end

	// ****************************************
	// checks
	// ****************************************
	idleDir_a: assert property (@(posedge clk) disable iff (!rst_b)
		!readStrobe |=> !xcvrSteer)
		else $error("transceiver not inward while not reading");

	readDir_a: assert property (@(posedge clk) disable iff (!rst_b)
		$fell(writeStrobe) && !readStrobe |=> $stable(xcvrSteer))
		else $error("direction moved when write ended");

	dirFirst_a: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(xcvrLowEn | xcvrHighEn | xcvrSwapEn) |-> $stable(xcvrSteer))
		else $error("transceiver enabled while direction changing");

	strobeQual_a: assert property (@(posedge clk) disable iff (!rst_b)
		!addrHit |=> !readStrobe && !writeStrobe)
		else $error("strobe without base match");

	ackRelease_a: assert property (@(posedge clk) disable iff (!rst_b)
		!boardSel |=> !xackOe && xackOut_n)
		else $error("acknowledge driven while deselected");

	ackEarly_a: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(boardSel) |=> xackOut_n [*8])
		else $error("acknowledge came too early");

	evenSel_a: assert property (@(posedge clk) disable iff (!rst_b)
		WIDE_BUS && chipGroup && !oddByte |=> !lowChipSel_n)
		else $error("even port did not select low chip");

	wordSel_a: assert property (@(posedge clk) disable iff (!rst_b)
		WIDE_BUS && chipGroup && bheSync[1] |=> !highChipSel_n)
		else $error("word access missed high chip");

	narrowSel_a: assert property (@(posedge clk) disable iff (!rst_b)
		!WIDE_BUS && chipGroup |=> lowChipSel_n != highChipSel_n)
		else $error("narrow variant selected both or no chip");

	statusHold_a: assert property (@(posedge clk) disable iff (!rst_b)
		statusOe && $past(statusOe) |-> $stable(statusData))
		else $error("status bit moved during read");

	intLine_a: assert property (@(posedge clk) disable iff (!rst_b)
		reqFlag |=> intLineOe && !intLineOut)
		else $error("interrupt line not pulled while requested");

endmodule : bus_io_slave

/* logic/slave_io_pkg.sv */
// shared constants for the bus i/o slave control logic
package slave_io_pkg;

	// ****************************************
	// address layout
	// ****************************************
	localparam int          ADDR_W          = 12;
	localparam int          BASE_W          = 8;
	localparam int          PORT_LSB        = 0;
	localparam int          PORT_W          = 4;
	localparam int          BASE_LO_LSB     = 4;
	localparam int          BASE_HI_LSB     = 8;
	localparam int          GROUP_BIT       = 3;
	localparam int          LANE_BIT        = 0;
	localparam int          NARROW_HALF_BIT = 2;
	localparam logic [3:0]  PORT_IRQ_STATUS = 4'h0;
	localparam logic [7:0]  BASE_DEFAULT    = 8'he3;

	// ****************************************
	// interrupt status port layout
	// ****************************************
	localparam int          STATUS_W        = 8;
	localparam int          STATUS_BIT      = 0;
	localparam logic        IRQ_RESET_VAL   = 1'b0;

	// ****************************************
	// acknowledge timing
	// ****************************************
	localparam int          CLK_PERIOD_NS   = 4;
	localparam int          CCLK_PERIOD_NS  = 100;
	localparam int          CHIP_VALID_NS   = 250;
	localparam int          ADDR_SETUP_NS   = 50;
	localparam int          ADDR_SETUP_CYC  = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          ACK_DEPTH       = 8;
	localparam int          ACK_TAP         = (CHIP_VALID_NS + CCLK_PERIOD_NS - 1) / CCLK_PERIOD_NS;
	localparam int          SYNC_STAGES     = 2;

endpackage : slave_io_pkg

/* logic/ack_delay.sv */
// acknowledge delay shift register stepped by the constant bus clock
`timescale 1ns/100ps

module ack_delay
	import slave_io_pkg::*;
#(
	parameter int DEPTH = slave_io_pkg::ACK_DEPTH
) (
	// clock and reset
	input  wire logic                             clk,
	input  wire logic                             rst_b,
	// control
	input  wire logic                             boardSel,
	input  wire logic                             cclkTick,
	input  wire logic [$clog2(DEPTH)-1:0]         tapSel,
	// acknowledge
	output logic                                  ackDone
);
	import slave_io_pkg::*;

	logic [DEPTH-1:0] stages;

	// ****************************************
	// shift register
	// ****************************************
	// the constant clock is unrelated to the bus command, so one period of slop
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stages <= '0;
		end else if (!boardSel) begin
			stages <= '0;
		end else if (cclkTick) begin
			stages <= {stages[DEPTH-2:0], 1'b1};
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ackDone <= 1'b0;
		end else begin
			ackDone <= boardSel & stages[tapSel];
		end
	end

	// ****************************************
	// checks
	// ****************************************
	clearIdle_a: assert property (@(posedge clk) disable iff (!rst_b)
		!boardSel |=> stages == '0 && !ackDone)
		else $error("shift register not held clear while idle");

	shiftOne_a: assert property (@(posedge clk) disable iff (!rst_b)
		boardSel && cclkTick && $past(boardSel) |=> stages == {$past(stages[DEPTH-2:0]), 1'b1})
		else $error("shift register did not step on constant clock");

endmodule : ack_delay

/* logic/irq_latch.sv */
// interrupt request and status latch pair
`timescale 1ns/100ps

module irq_latch (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// events
	input  wire logic reqRise,
	input  wire logic statusRead,
	input  wire logic statusWrite,
	// state
	output logic      reqFlag,
	output logic      statusFlag
);
	import slave_io_pkg::*;

	// ****************************************
	// request flag
	// ****************************************
	// a request arriving with the clearing write still counts
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reqFlag <= IRQ_RESET_VAL;
		end else if (reqRise) begin
			reqFlag <= 1'b1;
		end else if (statusWrite) begin
			reqFlag <= 1'b0;
		end
	end

	// ****************************************
	// status flag
	// ****************************************
	// captured once at the start of the read so d0 stays still under the master
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			statusFlag <= IRQ_RESET_VAL;
		end else if (statusRead) begin
			statusFlag <= reqFlag;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	irqClear_a: assert property (@(posedge clk) disable iff (!rst_b)
		statusWrite && !reqRise |=> !reqFlag)
		else $error("write to status port did not clear request");

	irqSetWins_a: assert property (@(posedge clk) disable iff (!rst_b)
		reqRise |=> reqFlag)
		else $error("interrupt request lost");

	statusCopy_a: assert property (@(posedge clk) disable iff (!rst_b)
		statusRead |=> statusFlag == $past(reqFlag))
		else $error("status flag not copied from request");

endmodule : irq_latch

/* sim/bus_master.sv */
// bus master model: i/o commands, address and the constant clock
`timescale 1ns/100ps

module bus_master
	import slave_io_pkg::*;
(
	// clock
	input  wire logic                         clk,
	// bus pins, pulled up when released
	output logic                              ioReadCmd_n,
	output logic                              ioWriteCmd_n,
	output logic [slave_io_pkg::ADDR_W-1:0]   addr_n,
	output logic                              byteHighEnable_n,
	output logic                              constClk_n,
	// acknowledge as seen on the bus
	input  wire logic                         xackLine
);
	// ****************************************
	// constant clock, free running
	// ****************************************
	logic [3:0] ccnt;
	logic       half;

	initial begin
		ioReadCmd_n = 1'b1;
		ioWriteCmd_n = 1'b1;
		addr_n = '1;
		byteHighEnable_n = 1'b1;
		constClk_n = 1'b1;
		ccnt = 4'h0;
		half = 1'b0;
	end

	// 12 + 13 cycles make one 100 ns period
	always @(posedge clk) begin
		if (ccnt == (half ? 4'hc : 4'hb)) begin
			ccnt <= 4'h0;
			half <= ~half;
			constClk_n <= ~constClk_n;
		end else begin
			ccnt <= ccnt + 4'h1;
		end
	end

	// ****************************************
	// one command, address leads and trails it
	// ****************************************
	task automatic access(input logic [ADDR_W-1:0] a, input logic bhe, input logic rd, input int lim);
		int n;
		n = 0;
		addr_n <= ~a;
		byteHighEnable_n <= ~bhe;
		repeat (ADDR_SETUP_CYC) @(posedge clk);
		if (rd)
			ioReadCmd_n <= 1'b0;
		else
			ioWriteCmd_n <= 1'b0;
		do begin
			@(posedge clk);
			n++;
		end while (xackLine !== 1'b0 && n < lim);
		ioReadCmd_n <= 1'b1;
		ioWriteCmd_n <= 1'b1;
		repeat (ADDR_SETUP_CYC) @(posedge clk);
		addr_n <= '1;
		byteHighEnable_n <= 1'b1;
	endtask : access

endmodule : bus_master

/* sim/tb_top.sv */
// self-checking bench for the bus i/o slave control logic
`timescale 1ns/100ps

module tb_top import slave_io_pkg::*;;
	localparam int CCYC = CCLK_PERIOD_NS / CLK_PERIOD_NS;
	typedef struct packed {
		logic       stat;
		logic       statBit;
		logic [9:0] pins;
	} note_t;

	logic                clk = 1'b0;
	logic                rst_b, ioReadCmd_n, ioWriteCmd_n, byteHighEnable_n, constClk_n, narrowHost, extIrqReq;
	logic [ADDR_W-1:0]   addr_n;
	logic [BASE_W-1:0]   baseAddr;
	logic                xackOut_n, xackOe, intLineOut, intLineOe, xcvrSteer, xcvrLowEn, xcvrHighEn, xcvrSwapEn;
	logic [STATUS_W-1:0] statusData;
	logic                statusOe, lowChipSel_n, highChipSel_n, chipRead_n, chipWrite_n;
	logic [1:0]          chipAddr;
	logic                xackLine, anyEn, pXack, pEn, pSteer, expReq;
	logic [31:0]         seed;
	note_t               notes[$];
	note_t               nt;
	int                  failures = 0, compares = 0, sinceSel = 0, sinceRd = 0, i, j;

	always #2 clk = ~clk;
	// acknowledge line has a pull-up
	assign xackLine = xackOe ? xackOut_n : 1'b1;
	assign anyEn = xcvrLowEn | xcvrHighEn | xcvrSwapEn;

	bus_master u_bus_master (.clk, .ioReadCmd_n, .ioWriteCmd_n, .addr_n, .byteHighEnable_n, .constClk_n, .xackLine);

	bus_io_slave #(.WIDE_BUS(1'b1), .ACK_SEL(ACK_TAP)) u_bus_io_slave (
		.clk, .rst_b, .ioReadCmd_n, .ioWriteCmd_n, .addr_n, .byteHighEnable_n, .constClk_n,
		.baseAddr, .narrowHost, .extIrqReq, .xackOut_n, .xackOe, .intLineOut, .intLineOe,
		.xcvrSteer, .xcvrLowEn, .xcvrHighEn, .xcvrSwapEn, .statusData, .statusOe,
		.lowChipSel_n, .highChipSel_n, .chipAddr, .chipRead_n, .chipWrite_n
	);

	// ****************************************
	// compare and report
	// ****************************************
	task automatic check_vec(input logic [15:0] got, input logic [15:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %0t %s got %h want %h", $time, msg, got, exp);
		end
	endtask : check_vec

	task automatic check_range(input int got, input int lo, input int hi, input string msg);
		compares++;
		if (got < lo || got > hi) begin
			failures++;
			$display("unexpected %0t %s %0d not in %0d..%0d", $time, msg, got, lo, hi);
		end
	endtask : check_range

	task automatic test_end(input string name);
		$display("test %s finished at %0t", name, $time);
	endtask : test_end

	task automatic test_done;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// {steer, low, high, swap, lowSel_n, highSel_n, read_n, write_n, chip address}
	function automatic logic [9:0] exp_pins(input logic [3:0] p, input logic bhe, input logic rd);
		logic o;
		o = p[0];
		if (!p[3])
			return {rd, 3'b100, 4'b1111, p[2:1]};
		return {rd, !o, !o && bhe, o, o, !(o || bhe), !rd, rd, p[2:1]};
	endfunction : exp_pins

	// ****************************************
	// stimulus tasks
	// ****************************************
	task automatic go(input logic [11:0] a, input logic bhe, input logic rd);
		note_t n;
		n.pins = exp_pins(a[3:0], bhe, rd);
		n.stat = rd && a[3:0] == PORT_IRQ_STATUS;
		n.statBit = expReq;
		notes.push_back(n);
		u_bus_master.access(a, bhe, rd, 400);
		if (!rd && a[3:0] == PORT_IRQ_STATUS)
			expReq = 1'b0;
		repeat (2) @(posedge clk);
		check_vec({xackOe, xcvrSteer, anyEn, statusOe, intLineOut, intLineOe}, {5'h0, expReq}, "idle");
	endtask : go

	task automatic irq_rise;
		int n;
		n = 0;
		extIrqReq <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (intLineOe !== 1'b1 && n < 10);
		check_vec({intLineOe, intLineOut}, 16'h2, "interrupt line");
		expReq = 1'b1;
	endtask : irq_rise

	// ****************************************
	// watcher: results taken in order of notes
	// ****************************************
	always @(posedge clk) begin
		pXack <= xackOut_n;
		pEn <= anyEn;
		pSteer <= xcvrSteer;
		sinceSel <= xackOe ? sinceSel + 1 : 0;
		sinceRd <= chipRead_n ? 0 : sinceRd + 1;
		if (anyEn === 1'b1 && pEn === 1'b0)
			check_vec(xcvrSteer, pSteer, "direction moved with enable");
		if (xackOe === 1'b1 && xackOut_n === 1'b0 && pXack === 1'b1) begin
			if (notes.size() == 0) begin
				check_vec(16'h1, 16'h0, "acknowledge without command");
			end else begin
				nt = notes.pop_front();
				check_vec({xcvrSteer, xcvrLowEn, xcvrHighEn, xcvrSwapEn, lowChipSel_n, highChipSel_n,
					chipRead_n, chipWrite_n, chipAddr}, nt.pins, "lanes");
				check_range(sinceSel, ACK_TAP * CCYC, (ACK_TAP + 1) * CCYC + 8, "ack delay");
				if (!nt.pins[3])
					check_range(sinceRd, CHIP_VALID_NS / CLK_PERIOD_NS, 1000, "read time");
				if (nt.stat)
					check_vec({statusOe, statusData}, {8'h1, 7'h0, nt.statBit}, "status");
			end
		end
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		rst_b = 1'b0;
		extIrqReq = 1'b0;
		baseAddr = BASE_DEFAULT;
		narrowHost = 1'b0;
		expReq = 1'b0;
		seed = 32'he2f3;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		check_vec({xackOe, intLineOe, anyEn, xcvrSteer, lowChipSel_n, highChipSel_n}, 16'h3, "reset");
		go(12'he30, 1'b0, 1'b1);
		irq_rise();
		go(12'he30, 1'b0, 1'b1);
		go(12'he30, 1'b0, 1'b0);
		go(12'he30, 1'b0, 1'b1);
		extIrqReq <= 1'b0;
		test_end("interrupt");
		for (i = 8; i < 16; i++)
			for (j = 0; j < 4; j++)
				go({BASE_DEFAULT, i[3:0]}, j[0], j[1]);
		test_end("chip selects");
		for (i = 0; i < 16; i++) begin
			seed = lfsr(seed);
			go({BASE_DEFAULT, 1'b1, seed[2:0]}, seed[3], seed[4]);
		end
		test_end("random");
		// high address bits ignored only for narrow hosts
		narrowHost <= 1'b1;
		repeat (4) @(posedge clk);
		go(12'h53a, 1'b0, 1'b1);
		narrowHost <= 1'b0;
		repeat (4) @(posedge clk);
		u_bus_master.access(12'h53a, 1'b0, 1'b1, 150);
		@(posedge clk);
		u_bus_master.access(12'he40, 1'b0, 1'b0, 150);
		repeat (4) @(posedge clk);
		check_vec(16'(notes.size()), 16'h0, "missed acknowledge");
		test_end("address match");
		test_done();
	end

	// watchdog well beyond the expected run length
	initial begin
		repeat (30000) @(posedge clk);
		failures++;
		$display("unexpected %0t watchdog expired", $time);
		test_done();
	end

endmodule : tb_top
